// [ms_regs_pkg.sv]
// Purpose: Shared constants and types for the master/slave register pair
// Assumes: 16-bit management registers reached by a plain register port
// Notes: Offsets are register indices on a 5-bit register address
package ms_regs_pkg;
	localparam int ADDR_W = 5;
	localparam int DATA_W = 16;
	localparam int IDLE_W = 8;
	localparam int FAIL_W = 3;

	localparam logic [ADDR_W-1:0] OFF_AN_CTRL = 5'h00;
	localparam logic [ADDR_W-1:0] OFF_ROLE_CTRL = 5'h09;
	localparam logic [ADDR_W-1:0] OFF_ROLE_STAT = 5'h0A;
	localparam logic [ADDR_W-1:0] OFF_XOVER_CTRL = 5'h10;

	localparam int AN_SWRST_BIT = 15;
	localparam int AN_ENABLE_BIT = 12;
	localparam int AN_RESTART_BIT = 9;

	localparam int TM_HI = 15;
	localparam int TM_LO = 13;
	localparam int MAN_EN_BIT = 12;
	localparam int MAN_VAL_BIT = 11;
	localparam int PORT_TYPE_BIT = 10;
	localparam int ADV_FD_BIT = 9;
	localparam int ADV_HD_BIT = 8;

	localparam int FAULT_BIT = 15;
	localparam int RES_BIT = 14;
	localparam int LRX_BIT = 13;
	localparam int RRX_BIT = 12;
	localparam int LP_FD_BIT = 11;
	localparam int LP_HD_BIT = 10;
	localparam int IDLE_HI = 7;

	localparam int XO_HI = 6;
	localparam int XO_LO = 5;

	localparam logic MAN_EN_RST = 1'b0;
	localparam logic MAN_VAL_RST = 1'b1;
	localparam logic PORT_TYPE_RST = 1'b1;
	localparam logic ADV_FD_RST = 1'b1;
	localparam logic AN_EN_RST = 1'b1;
	localparam logic [FAIL_W-1:0] FAIL_LIMIT = 3'h7;

	typedef enum logic [2:0] {
		TM_NORMAL = 3'h0,
		TM_WAVEFORM = 3'h1,
		TM_JITTER_MASTER = 3'h2,
		TM_JITTER_SLAVE = 3'h3
	} tx_test_t;

	typedef enum logic [1:0] {
		XO_STRAIGHT = 2'h0,
		XO_CROSSED = 2'h1,
		XO_AUTO = 2'h3
	} xover_t;

	typedef struct packed {
		logic man_en;
		logic man_master;
		logic prefer_master;
		logic adv_fd;
		logic adv_hd;
	} role_cfg_t;

	typedef struct packed {
		logic an_complete;
		logic page_rx;
		logic res_fail;
		logic partner_forced;
		logic partner_master;
		logic resolved_master;
		logic local_rx_ok;
		logic remote_rx_ok;
		logic lp_fd;
		logic lp_hd;
		logic idle_err;
	} phy_stat_t;
endpackage

// [idle_err_counter.sv]
// Purpose: Saturating error counter cleared by a status read
// Assumes: Inputs synchronous to mclk_in
// Notes: An error in the read cycle survives as a count of one
`timescale 1ns/1ps
module idle_err_counter #(
	parameter int W = 8
) (
	input wire logic mclk_in,
	input wire logic rst_in,
	input wire logic soft_clr_in,
	input wire logic rd_clr_in,
	input wire logic inc_in,
	output logic [W-1:0] count_out
);
	localparam logic [W-1:0] FULL = {W{1'b1}};
	localparam logic [W-1:0] ONE = {{(W-1){1'b0}}, 1'b1};

	logic [W-1:0] next_count;

	if (W < 2) begin : g_bad_width
		$error("idle_err_counter: W must be at least 2");
	end

	always_comb begin
		next_count = count_out;
		if (soft_clr_in) begin
			next_count = '0;
		end else if (rd_clr_in) begin
			next_count = inc_in ? ONE : '0;
		end else if (inc_in && count_out != FULL) begin
			next_count = count_out + ONE;
		end
	end

	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			count_out <= '0;
		end else begin
			count_out <= next_count;
		end
	end

	property p_idle_sat;
		@(posedge mclk_in) disable iff (rst_in)
		(count_out == FULL && inc_in && !rd_clr_in && !soft_clr_in)
		|=> count_out == FULL;
	endproperty
	a_idle_sat: assert property (p_idle_sat)
		else $error("idle count wrapped");

	property p_idle_inc;
		@(posedge mclk_in) disable iff (rst_in)
		(count_out != FULL && inc_in && !rd_clr_in && !soft_clr_in)
		|=> count_out == $past(count_out) + ONE;
	endproperty
	a_idle_inc: assert property (p_idle_inc)
		else $error("idle count missed an error");

	property p_idle_rdclr;
		@(posedge mclk_in) disable iff (rst_in)
		(rd_clr_in && !inc_in) |=> count_out == '0;
	endproperty
	a_idle_rdclr: assert property (p_idle_rdclr)
		else $error("idle count not cleared by read");

	c_idle_full: cover property (@(posedge mclk_in) disable iff (rst_in)
		count_out == FULL && inc_in);
endmodule

// [ms_role_regs.sv]
// Purpose: Master/slave control and status registers of the copper PHY
// Assumes: Register port with read data one cycle after the read strobe
// Notes: Role and advertisement settings apply on negotiation restart
//
// Function
// - Decode three-bit transmitter test mode
// - Test modes only with crossover disabled
// - Manual enable fixes role from value bit
// - Role settings apply on negotiation restart
// - Value bit: one master, zero slave
// - Port type preference used without manual
// - Advertise full duplex per its bit
// - Half duplex advertise, reset per variant
// - Fault bit latches, clears on read
// - Fault clears on negotiation enable/complete
// - Fault set at seven failed resolutions
// - Fault set when both forced alike
// - Resolution bit shows master or slave
// - Local receiver status bit
// - Remote receiver status bit
// - Partner abilities valid with page received
// - Eight-bit idle error counter increments
// - Idle counter saturates, never wraps
// - Crossover mode applies after software reset
`timescale 1ns/1ps
module ms_role_regs
	import ms_regs_pkg::*;
#(
	parameter logic ADV_HD_DEFAULT = 1'b1,
	parameter int CNT_W = IDLE_W
) (
	input wire logic mclk_in,
	input wire logic rst_in,
	input wire logic [ADDR_W-1:0] addr_in,
	input wire logic [DATA_W-1:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	input wire phy_stat_t stat_in,
	output logic [DATA_W-1:0] rdata_out,
	output role_cfg_t cfg_out,
	output tx_test_t test_mode_out,
	output xover_t xover_out,
	output logic an_enable_out,
	output logic an_restart_out,
	output logic soft_reset_out,
	output logic fault_out
);
	if (CNT_W < 2 || CNT_W > IDLE_HI + 1) begin : g_bad_cnt
		$error("ms_role_regs: CNT_W must lie in 2..8");
	end

	localparam role_cfg_t CFG_RST = '{
		man_en: MAN_EN_RST,
		man_master: MAN_VAL_RST,
		prefer_master: PORT_TYPE_RST,
		adv_fd: ADV_FD_RST,
		adv_hd: ADV_HD_DEFAULT
	};

	// Written settings, counters and delayed status
	tx_test_t tm;
	role_cfg_t pend;
	xover_t xo_pend;
	logic [FAIL_W-1:0] fail_cnt;
	logic an_done_q;
	logic [CNT_W-1:0] idle_cnt;

	// Decoded strobes, fault terms, read words and decoded write value
	logic wr_an;
	logic wr_ctrl;
	logic wr_xo;
	logic rd_stat;
	logic soft_rst;
	logic restart;
	logic an_en_rise;
	logic an_done_rise;
	logic conflict;
	logic fail_hit;
	logic fault_set;
	logic fault_clr;
	logic [DATA_W-1:0] next_rdata;
	logic [DATA_W-1:0] ctrl_word;
	logic [DATA_W-1:0] stat_word;
	logic [DATA_W-1:0] an_word;
	logic [DATA_W-1:0] xo_word;
	xover_t xo_wval;

	assign wr_an = wr_in && addr_in == OFF_AN_CTRL;
	assign wr_ctrl = wr_in && addr_in == OFF_ROLE_CTRL;
	assign wr_xo = wr_in && addr_in == OFF_XOVER_CTRL;
	assign rd_stat = rd_in && addr_in == OFF_ROLE_STAT;
	assign soft_rst = wr_an && wdata_in[AN_SWRST_BIT];
	// Enabling negotiation also starts it, as a restart would
	assign an_en_rise = wr_an && wdata_in[AN_ENABLE_BIT] && !an_enable_out;
	assign restart = wr_an && wdata_in[AN_ENABLE_BIT]
		&& (wdata_in[AN_RESTART_BIT] || !an_enable_out);
	assign an_done_rise = stat_in.an_complete && !an_done_q;

	// Unsupported field codes fall back to automatic crossover
	always_comb begin
		case (wdata_in[XO_HI:XO_LO])
			2'h0: xo_wval = XO_STRAIGHT;
			2'h1: xo_wval = XO_CROSSED;
			default: xo_wval = XO_AUTO;
		endcase
	end

	// Only a forced local role can clash with a forced partner
	assign conflict = cfg_out.man_en && stat_in.partner_forced
		&& (stat_in.partner_master == cfg_out.man_master);
	// A saturated count keeps flagging each later failure
	assign fail_hit = stat_in.res_fail
		&& fail_cnt >= FAIL_LIMIT - 3'h1;
	assign fault_set = conflict || fail_hit;
	assign fault_clr = rd_stat || an_en_rise || an_done_rise;

	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			an_done_q <= 1'b0;
		end else begin
			an_done_q <= stat_in.an_complete;
		end
	end

	// Test mode field returns to normal on software reset
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			tm <= TM_NORMAL;
		end else if (soft_rst) begin
			tm <= TM_NORMAL;
		end else if (wr_ctrl) begin
			tm <= tx_test_t'(wdata_in[TM_HI:TM_LO]);
		end
	end

	// Pending role settings survive software reset
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			pend <= CFG_RST;
		end else if (wr_ctrl) begin
			pend.man_en <= wdata_in[MAN_EN_BIT];
			pend.man_master <= wdata_in[MAN_VAL_BIT];
			pend.prefer_master <= wdata_in[PORT_TYPE_BIT];
			pend.adv_fd <= wdata_in[ADV_FD_BIT];
			pend.adv_hd <= wdata_in[ADV_HD_BIT];
		end
	end

	// Negotiation sees only settings captured at the restart
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			cfg_out <= CFG_RST;
		end else if (restart) begin
			cfg_out <= pend;
		end
	end

	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			an_enable_out <= AN_EN_RST;
			an_restart_out <= 1'b0;
			soft_reset_out <= 1'b0;
		end else begin
			if (wr_an) begin
				an_enable_out <= wdata_in[AN_ENABLE_BIT];
			end
			an_restart_out <= restart;
			soft_reset_out <= soft_rst;
		end
	end

	// Crossover changes wait for software reset, so the pair
	// mapping never moves under a live link
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			xo_pend <= XO_AUTO;
			xover_out <= XO_AUTO;
		end else begin
			if (wr_xo) begin
				xo_pend <= xo_wval;
			end
			if (soft_rst) begin
				xover_out <= wr_xo ? xo_wval : xo_pend;
			end
		end
	end

	// Test patterns are held off while crossover is automatic
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			test_mode_out <= TM_NORMAL;
		end else if (xover_out == XO_AUTO) begin
			test_mode_out <= TM_NORMAL;
		end else begin
			case (tm)
				TM_WAVEFORM: test_mode_out <= TM_WAVEFORM;
				TM_JITTER_MASTER: test_mode_out <= TM_JITTER_MASTER;
				TM_JITTER_SLAVE: test_mode_out <= TM_JITTER_SLAVE;
				default: test_mode_out <= TM_NORMAL;
			endcase
		end
	end

	// Failed resolutions restart counting with each negotiation
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			fail_cnt <= '0;
		end else if (soft_rst || restart || an_done_rise) begin
			fail_cnt <= '0;
		end else if (stat_in.res_fail && fail_cnt != FAIL_LIMIT) begin
			fail_cnt <= fail_cnt + 3'h1;
		end
	end

	// A new fault in the clearing cycle wins over a read or negotiation clear, but not over software reset
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			fault_out <= 1'b0;
		end else if (soft_rst) begin
			fault_out <= 1'b0;
		end else if (fault_set) begin
			fault_out <= 1'b1;
		end else if (fault_clr) begin
			fault_out <= 1'b0;
		end
	end

	idle_err_counter #(
		.W(CNT_W)
	) u_idle_cnt (
		.mclk_in(mclk_in),
		.rst_in(rst_in),
		.soft_clr_in(soft_rst),
		.rd_clr_in(rd_stat),
		.inc_in(stat_in.idle_err),
		.count_out(idle_cnt)
	);

	always_comb begin
		ctrl_word = '0;
		ctrl_word[TM_HI:TM_LO] = tm;
		ctrl_word[MAN_EN_BIT] = pend.man_en;
		ctrl_word[MAN_VAL_BIT] = pend.man_master;
		ctrl_word[PORT_TYPE_BIT] = pend.prefer_master;
		ctrl_word[ADV_FD_BIT] = pend.adv_fd;
		ctrl_word[ADV_HD_BIT] = pend.adv_hd;
		stat_word = '0;
		stat_word[FAULT_BIT] = fault_out;
		stat_word[RES_BIT] = stat_in.resolved_master;
		stat_word[LRX_BIT] = stat_in.local_rx_ok;
		stat_word[RRX_BIT] = stat_in.remote_rx_ok;
		// Partner bits pass through; readers check page received
		stat_word[LP_FD_BIT] = stat_in.lp_fd;
		stat_word[LP_HD_BIT] = stat_in.lp_hd;
		stat_word[CNT_W-1:0] = idle_cnt;
		an_word = '0;
		an_word[AN_ENABLE_BIT] = an_enable_out;
		xo_word = '0;
		xo_word[XO_HI:XO_LO] = xo_pend;
	end

	// Read data stand only in the cycle after the strobe
	always_comb begin
		next_rdata = '0;
		if (rd_in) begin
			case (addr_in)
				OFF_AN_CTRL: next_rdata = an_word;
				OFF_ROLE_CTRL: next_rdata = ctrl_word;
				OFF_ROLE_STAT: next_rdata = stat_word;
				OFF_XOVER_CTRL: next_rdata = xo_word;
				default: next_rdata = '0;
			endcase
		end
	end

	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			rdata_out <= '0;
		end else begin
			rdata_out <= next_rdata;
		end
	end

	property p_test_gate;
		@(posedge mclk_in) disable iff (rst_in)
		xover_out == XO_AUTO |=> test_mode_out == TM_NORMAL;
	endproperty
	a_test_gate: assert property (p_test_gate)
		else $error("test mode entered with auto crossover");

	property p_test_decode;
		@(posedge mclk_in) disable iff (rst_in)
		(xover_out != XO_AUTO && tm == TM_JITTER_SLAVE)
		|=> test_mode_out == TM_JITTER_SLAVE;
	endproperty
	a_test_decode: assert property (p_test_decode)
		else $error("test mode not decoded");

	property p_cfg_apply;
		@(posedge mclk_in) disable iff (rst_in)
		!$stable(cfg_out) |-> an_restart_out;
	endproperty
	a_cfg_apply: assert property (p_cfg_apply)
		else $error("role settings changed without restart");

	property p_fault_rdclr;
		@(posedge mclk_in) disable iff (rst_in)
		(rd_stat && !fault_set) |=> !fault_out;
	endproperty
	a_fault_rdclr: assert property (p_fault_rdclr)
		else $error("fault not cleared by read");

	property p_fault_done;
		@(posedge mclk_in) disable iff (rst_in)
		(an_done_rise && !fault_set) |=> !fault_out;
	endproperty
	a_fault_done: assert property (p_fault_done)
		else $error("fault not cleared on completion");

	property p_fault_seven;
		@(posedge mclk_in) disable iff (rst_in)
		(stat_in.res_fail && fail_cnt == 3'h6 && !soft_rst) |=> fault_out;
	endproperty
	a_fault_seven: assert property (p_fault_seven)
		else $error("fault not set at seven failures");

	property p_fault_forced;
		@(posedge mclk_in) disable iff (rst_in)
		(conflict && !soft_rst) |=> fault_out;
	endproperty
	a_fault_forced: assert property (p_fault_forced)
		else $error("forced role clash not flagged");

	property p_res_read;
		@(posedge mclk_in) disable iff (rst_in)
		rd_stat |=> rdata_out[RES_BIT] == $past(stat_in.resolved_master)
			&& rdata_out[LRX_BIT] == $past(stat_in.local_rx_ok);
	endproperty
	a_res_read: assert property (p_res_read)
		else $error("status readback wrong");

	property p_soft_keep;
		@(posedge mclk_in) disable iff (rst_in)
		(soft_rst && !wr_ctrl) |=> $stable(pend) && tm == TM_NORMAL;
	endproperty
	a_soft_keep: assert property (p_soft_keep)
		else $error("software reset disturbed role settings");

	property p_xo_apply;
		@(posedge mclk_in) disable iff (rst_in)
		!$stable(xover_out) |-> soft_reset_out;
	endproperty
	a_xo_apply: assert property (p_xo_apply)
		else $error("crossover changed without software reset");

	c_fault: cover property (@(posedge mclk_in) disable iff (rst_in)
		fail_hit);
	c_restart: cover property (@(posedge mclk_in) disable iff (rst_in)
		restart && pend != cfg_out);
	c_test: cover property (@(posedge mclk_in) disable iff (rst_in)
		test_mode_out == TM_WAVEFORM);
endmodule

// [phy_partner_model.sv]
// Purpose: Link partner and PHY core status source for the role registers
// Assumes: Bench steers partner role, receiver health and error bursts
// Notes: Abilities show only once a page arrives, as on a real link
`timescale 1ns/1ps
module phy_partner_model
	import ms_regs_pkg::*;
(
	input wire logic mclk_in,
	input wire logic rst_in,
	input wire role_cfg_t cfg_in,
	input wire logic forced_in,
	input wire logic master_in,
	input wire logic [3:0] caps_in,
	input wire logic done_in,
	input wire logic fail_in,
	input wire logic idle_in,
	output phy_stat_t stat_out
);
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			stat_out <= '0;
		end else begin
			stat_out.an_complete <= done_in;
			stat_out.page_rx <= done_in;
			stat_out.res_fail <= fail_in;
			stat_out.partner_forced <= forced_in;
			stat_out.partner_master <= master_in;
			// Local manual choice wins, else take the role a forced partner leaves over, else the port preference
			stat_out.resolved_master <= cfg_in.man_en ? cfg_in.man_master :
				(forced_in ? !master_in : cfg_in.prefer_master);
			stat_out.local_rx_ok <= caps_in[3];
			stat_out.remote_rx_ok <= caps_in[2];
			// Abilities are meaningless until a page has been received
			stat_out.lp_fd <= done_in & caps_in[1];
			stat_out.lp_hd <= done_in & caps_in[0];
			stat_out.idle_err <= idle_in;
		end
	end
endmodule

// [test_ms_role_regs.sv]
// Purpose: Self-checking bench for the master/slave register pair
// Assumes: Partner model supplies status; bench tracks expected state
// Notes: Status reaches the design two edges after the bench steers it
`timescale 1ns/1ps
module test_ms_role_regs
	import ms_regs_pkg::*;
;
	logic mclk_in = 1'h0;
	logic rst_in = 1'h1;
	logic [ADDR_W-1:0] addr = '0;
	logic [DATA_W-1:0] wdata = '0;
	logic wr = 1'h0;
	logic rd = 1'h0;
	logic forced = 1'h0;
	logic master = 1'h0;
	logic done = 1'h0;
	logic fail = 1'h0;
	logic idle = 1'h0;
	logic [3:0] caps = '0;
	phy_stat_t stat;
	logic [DATA_W-1:0] rdata;
	role_cfg_t cfg;
	tx_test_t tmode;
	xover_t xo;
	logic an_en;
	logic an_rst;
	logic sw_rst;
	logic fault;
	int errors = 0;
	int total_checks = 0;
	int m_reg9;
	int m_cfg;
	int m_idle;
	int n;
	int i;
	logic [15:0] v;

	always #25 mclk_in = ~mclk_in;

	ms_role_regs dut (.mclk_in(mclk_in), .rst_in(rst_in), .addr_in(addr),
		.wdata_in(wdata), .wr_in(wr), .rd_in(rd), .stat_in(stat),
		.rdata_out(rdata), .cfg_out(cfg), .test_mode_out(tmode),
		.xover_out(xo), .an_enable_out(an_en), .an_restart_out(an_rst),
		.soft_reset_out(sw_rst), .fault_out(fault));
	phy_partner_model partner (.mclk_in(mclk_in), .rst_in(rst_in),
		.cfg_in(cfg), .forced_in(forced), .master_in(master),
		.caps_in(caps), .done_in(done), .fail_in(fail), .idle_in(idle),
		.stat_out(stat));

	task automatic test_done;
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic cyc(input int k);
		repeat (k) @(posedge mclk_in);
	endtask

	task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
		@(posedge mclk_in);
		wr <= 1'h1;
		addr <= a;
		wdata <= d;
		@(posedge mclk_in);
		wr <= 1'h0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rd_reg(input logic [4:0] a, output logic [15:0] d);
		@(posedge mclk_in);
		rd <= 1'h1;
		addr <= a;
		@(posedge mclk_in);
		rd <= 1'h0;
		#1 d = rdata;
	endtask

	// One event per high cycle of the chosen error line
	task automatic pulse(input logic sel, input int k);
		repeat (k) begin
			@(posedge mclk_in);
			fail <= sel;
			idle <= !sel;
		end
		@(posedge mclk_in);
		fail <= 1'h0;
		idle <= 1'h0;
		cyc(3);
	endtask

	task automatic wait_fault;
		n = 0;
		while (fault !== 1'h1 && n < 8) begin
			@(posedge mclk_in);
			n++;
		end
		if (fault !== 1'h1) begin
			errors++;
			test_done();
		end
	endtask

	function automatic logic [15:0] stat_word(input logic flt);
		logic rm;
		rm = m_cfg[4] ? m_cfg[3] : (forced ? !master : m_cfg[2]);
		return {flt, rm, caps[3:2], done & caps[1], done & caps[0], 2'h0,
			8'(m_idle)};
	endfunction

	initial begin
		void'($urandom(32'hBB7352D2));
		repeat (3) @(posedge mclk_in);
		rst_in <= 1'h0;
		m_reg9 = 16'h0F00;
		m_cfg = 5'h0F;
		m_idle = 0;
		rd_reg(OFF_ROLE_CTRL, v);
		check(v, m_reg9[15:0]);
		check({11'h0, cfg}, m_cfg[15:0]);
		check({8'h0, an_rst, sw_rst, an_en, tmode, xo}, 16'h0023);
		rd_reg(OFF_ROLE_STAT, v);
		check(v, stat_word(1'h0));
		$display("test reset values done");
		for (i = 0; i < 6; i++) begin
			@(posedge mclk_in);
			v = (i == 0) ? 16'h1800 : {3'h0, 5'($urandom), 8'h0};
			forced <= (i == 0) | 1'($urandom);
			master <= (i == 0) | 1'($urandom);
			caps <= 4'($urandom);
			wr_reg(OFF_ROLE_CTRL, v);
			m_reg9 = v;
			rd_reg(OFF_ROLE_CTRL, v);
			check(v, m_reg9[15:0]);
			check({11'h0, cfg}, m_cfg[15:0]);
			wr_reg(OFF_AN_CTRL, 16'h1200);
			#1 check({15'h0, an_rst}, 16'h0001);
			m_cfg = m_reg9[12:8];
			cyc(3);
			check({11'h0, cfg}, m_cfg[15:0]);
			if (i == 0) wait_fault();
			// First read may show a fault latched under the old setting
			rd_reg(OFF_ROLE_STAT, v);
			rd_reg(OFF_ROLE_STAT, v);
			check(v, stat_word(m_cfg[4] & forced & (master == m_cfg[3])));
		end
		$display("test role settings done");
		wr_reg(OFF_ROLE_CTRL, 16'h4000 | m_reg9[15:0]);
		cyc(2);
		check({13'h0, tmode}, 16'h0000);
		wr_reg(OFF_XOVER_CTRL, 16'h0020);
		cyc(2);
		check({14'h0, xo}, 16'h0003);
		rd_reg(OFF_XOVER_CTRL, v);
		check(v, 16'h0020);
		wr_reg(OFF_AN_CTRL, 16'h9000);
		#1 check({14'h0, sw_rst, an_rst}, 16'h0002);
		cyc(2);
		check({14'h0, xo}, 16'h0001);
		rd_reg(OFF_AN_CTRL, v);
		check(v, 16'h1000);
		rd_reg(OFF_ROLE_CTRL, v);
		check(v, m_reg9[15:0]);
		check({11'h0, cfg}, m_cfg[15:0]);
		for (i = 0; i < 5; i++) begin
			wr_reg(OFF_ROLE_CTRL, {i[2:0], m_reg9[12:0]});
			cyc(2);
			check({13'h0, tmode}, (i < 4) ? 16'(i) : 16'h0000);
		end
		$display("test test modes done");
		n = 1 + int'($urandom % 40);
		m_idle = n;
		pulse(1'h0, n);
		rd_reg(OFF_ROLE_STAT, v);
		check({8'h0, v[7:0]}, m_idle[15:0]);
		m_idle = 0;
		rd_reg(OFF_ROLE_STAT, v);
		check({8'h0, v[7:0]}, 16'h0000);
		pulse(1'h0, 300);
		rd_reg(OFF_ROLE_STAT, v);
		check({8'h0, v[7:0]}, 16'h00FF);
		$display("test idle counter done");
		@(posedge mclk_in);
		forced <= 1'h0;
		cyc(3);
		rd_reg(OFF_ROLE_STAT, v);
		pulse(1'h1, 6);
		check({15'h0, fault}, 16'h0000);
		pulse(1'h1, 1);
		wait_fault();
		rd_reg(OFF_ROLE_STAT, v);
		check(v, stat_word(1'h1));
		rd_reg(OFF_ROLE_STAT, v);
		check(v, stat_word(1'h0));
		pulse(1'h1, 1);
		wait_fault();
		done <= 1'h1;
		cyc(3);
		check({15'h0, fault}, 16'h0000);
		rd_reg(OFF_ROLE_STAT, v);
		check(v, stat_word(1'h0));
		wr_reg(OFF_AN_CTRL, 16'h0000);
		pulse(1'h1, 7);
		wait_fault();
		wr_reg(OFF_AN_CTRL, 16'h1000);
		#1 check({14'h0, an_en, fault}, 16'h0002);
		$display("test fault done");
		test_done();
	end
endmodule
